// ---- src/atsp_regs.vh ----
// register map, field layout and reset values of the trigger slot program block
`ifndef ATSP_REGS_VH
`define ATSP_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ATSP_OFF_SW_0_3       8'h00
`define ATSP_OFF_SW_4_7       8'h04
`define ATSP_OFF_SW_8_11      8'h08
`define ATSP_OFF_CONST_0_3    8'h0C
`define ATSP_OFF_CONST_4_7    8'h10
`define ATSP_OFF_CONST_8_11   8'h14
`define ATSP_OFF_CTRL         8'h18
`define ATSP_OFF_STATUS       8'h1C
`define ATSP_OFF_IRQ_STATUS   8'h20
`define ATSP_OFF_IRQ_CLEAR    8'h24
`define ATSP_OFF_IRQ_ENABLE   8'h28

// ****************************************************************
// slot field layout
// ****************************************************************
`define ATSP_SLOT_COUNT       12
`define ATSP_SLOT_LANE_W      8
`define ATSP_SLOT_EN_BIT      7
`define ATSP_SEL_W            5
`define ATSP_SLOT_WMASK       32'h9F9F_9F9F
`define ATSP_SLOT_RESET       32'h0000_0000
`define ATSP_SEL_MAX_UNIT_A   5'h0E
`define ATSP_SEL_MAX_UNIT_B   5'h10

// ****************************************************************
// control, status and interrupt bits
// ****************************************************************
`define ATSP_CTRL_SW_START    0
`define ATSP_CTRL_CONST_MODE  1
`define ATSP_STAT_BUSY        0
`define ATSP_STAT_CONST       1
`define ATSP_STAT_SW_PEND     2
`define ATSP_STAT_SLOT_LSB    4
`define ATSP_IRQ_SW_DONE      0
`define ATSP_IRQ_BAD_SEL      1
`define ATSP_IRQ_ABORT        2
`define ATSP_IRQ_W            3

`endif

// ---- src/atsp_slot_seq.v ----
// slot sequencer: walks the software or constant slot program and issues conversions
`timescale 1ns/1ps
`include "atsp_regs.vh"

module atsp_slot_seq #(
  parameter IS_UNIT_B = 0
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        sw_start,
  input  wire        const_mode,
  input  wire        hi_prio_trigger,
  input  wire        conv_done,
  input  wire [95:0] sw_slots,
  input  wire [95:0] const_slots,
  output reg         conv_start,
  output reg  [4:0]  conv_channel,
  output reg  [3:0]  conversion_result_slot,
  output reg         busy,
  output reg         const_active,
  output reg         sw_pending,
  output reg         sw_done_evt,
  output reg         bad_sel_evt,
  output reg         abort_evt
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SCAN = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  function slot_en;
    input [95:0] w;
    input [3:0]  idx;
    begin
      slot_en = w[idx * `ATSP_SLOT_LANE_W + `ATSP_SLOT_EN_BIT];
    end
  endfunction

  function [4:0] slot_sel;
    input [95:0] w;
    input [3:0]  idx;
    begin
      slot_sel = w[idx * `ATSP_SLOT_LANE_W +: `ATSP_SEL_W];
    end
  endfunction

  // codes above the unit's top input are reserved
  function sel_ok;
    input [4:0] code;
    begin
      sel_ok = (code <= `ATSP_SEL_MAX_UNIT_A) ||
               ((IS_UNIT_B != 0) && (code <= `ATSP_SEL_MAX_UNIT_B));
    end
  endfunction

  reg  [2:0] state;
  reg        prog_sw;
  reg  [3:0] idx;
  wire [95:0] cur_prog = prog_sw ? sw_slots : const_slots;
  wire        cur_en   = slot_en(cur_prog, idx);
  wire [4:0]  cur_sel  = slot_sel(cur_prog, idx);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // one slot is issued, then the core's done moves on to the next index
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                  <= ST_IDLE;
      prog_sw                <= 1'b0;
      idx                    <= 4'h0;
      conv_start             <= 1'b0;
      conv_channel           <= 5'h00;
      conversion_result_slot <= 4'h0;
      busy                   <= 1'b0;
      const_active           <= 1'b0;
      sw_pending             <= 1'b0;
      sw_done_evt            <= 1'b0;
      bad_sel_evt            <= 1'b0;
      abort_evt              <= 1'b0;
    end else begin
      conv_start  <= 1'b0;
      sw_done_evt <= 1'b0;
      bad_sel_evt <= 1'b0;
      abort_evt   <= 1'b0;
      if (sw_start)
        sw_pending <= 1'b1;
      case (state)
        ST_IDLE: begin
          idx <= 4'h0;
          if (!hi_prio_trigger && (sw_pending || sw_start)) begin
            prog_sw      <= 1'b1;
            busy         <= 1'b1;
            const_active <= 1'b0;
            state        <= ST_SCAN;
          end else if (!hi_prio_trigger && const_mode) begin
            prog_sw      <= 1'b0; // triggers stay armed while the mode is on
            busy         <= 1'b1;
            const_active <= 1'b1;
            state        <= ST_SCAN;
          end else begin
            busy         <= 1'b0;
            const_active <= 1'b0;
          end
        end
        ST_SCAN: begin
          if (hi_prio_trigger || (!prog_sw && sw_pending) || (!prog_sw && !const_mode)) begin
            abort_evt <= hi_prio_trigger || sw_pending;
            state     <= ST_IDLE;
          end else if (idx == `ATSP_SLOT_COUNT) begin
            if (prog_sw) begin
              sw_done_evt <= 1'b1;
              sw_pending  <= sw_start;
            end
            state <= ST_IDLE;
          end else if (cur_en && sel_ok(cur_sel)) begin
            conv_start             <= 1'b1;
            conv_channel           <= cur_sel;
            conversion_result_slot <= idx;
            state                  <= ST_WAIT;
          end else begin
            bad_sel_evt <= cur_en;
            idx         <= idx + 4'h1;
          end
        end
        ST_WAIT: begin
          if (hi_prio_trigger || (!prog_sw && sw_pending)) begin
            abort_evt <= 1'b1;
            state     <= ST_IDLE;
          end else if (conv_done) begin
            idx   <= idx + 4'h1;
            state <= ST_SCAN;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // atsp_slot_seq

// ---- src/atsp_top.v ----
// trigger slot program block: apb registers, interrupts and the slot sequencer
//
// Notes on behaviour
// - a constant mode keeps conversion triggers permanently armed from its own slots.
// - twelve constant slots, each in one byte lane of a packed word.
// - a constant slot converts only when its enable bit is one.
// - each constant slot holds a five-bit analog input selector.
// - slot m always delivers its result into result register m.
// - enables at bits 31,23,15,7; selectors at 28-24,20-16,12-8,4-0.
// - the two bits between enable and selector read zero, writes ignored.
// - codes 0..14 valid on both units; 15 and 16 only on unit b.
// - all slot program bits reset to zero.
// - software slots convert only when enabled, same selector coding.
// - finishing a software program raises the software done interrupt.
// - a higher priority trigger aborts the running program.
//
// register map, byte offsets
// 0x00-0x08  software slot words for slots 0-3, 4-7 and 8-11
// 0x0C-0x14  constant slot words, same lane layout
// 0x18       control: bit 0 start pulse, bit 1 constant mode
// 0x1C       status: busy, constant active, start pending, slot in 7:4
// 0x20       interrupt status: done, bad selector, abort
// 0x24       interrupt clear, a one clears the matching status bit
// 0x28       interrupt enable, same layout as the status
//
// limitations
// reserved selector codes are stored as written but never converted
// status reads are one cycle old, the answer is taken in setup
// a software start pre-empts the constant loop, which resumes after
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "atsp_regs.vh"

module atsp_top #(
  parameter IS_UNIT_B = 0
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        hi_prio_trigger,
  input  wire        conv_done,
  output wire        conv_start,
  output wire [4:0]  conv_channel,
  output wire [3:0]  conversion_result_slot,
  output reg         sw_conversion_done_irq
);

  // ****************************************************************
  // storage
  // ****************************************************************
  reg  [31:0]            sw_word [0:2];
  reg  [31:0]            const_word [0:2];
  reg                    const_mode;
  reg                    sw_start;
  reg  [`ATSP_IRQ_W-1:0] irq_status;
  reg  [`ATSP_IRQ_W-1:0] irq_enable;
  reg  [`ATSP_IRQ_W-1:0] next_irq_status;
  reg  [31:0]            next_prdata;
  reg                    next_slverr;

  wire        busy;
  wire        const_active;
  wire        sw_pending;
  wire        sw_done_evt;
  wire        bad_sel_evt;
  wire        abort_evt;
  wire [95:0] sw_slots    = {sw_word[2], sw_word[1], sw_word[0]};
  wire [95:0] const_slots = {const_word[2], const_word[1], const_word[0]};

  // write lands only at the access edge the master samples pready
  wire        wr_ok = psel & penable & pready & pwrite;

  // ****************************************************************
  // single register hits
  // ****************************************************************
  // one compare each, used only by the write paths; the read mux decodes paddr itself
  wire        hit_ctrl    = (paddr == `ATSP_OFF_CTRL);
  wire        hit_irq_clr = (paddr == `ATSP_OFF_IRQ_CLEAR);
  wire        hit_irq_en  = (paddr == `ATSP_OFF_IRQ_ENABLE);
  wire        setup_rd    = psel & ~penable & ~pwrite;

  // ****************************************************************
  // address decode helpers
  // ****************************************************************
  // index of a packed slot word, or 2'd3 when the address is not one
  function [1:0] word_index;
    input [7:0] a;
    input       is_const;
    begin
      word_index = 2'd3;
      if (is_const) begin
        case (a)
          `ATSP_OFF_CONST_0_3:  word_index = 2'd0;
          `ATSP_OFF_CONST_4_7:  word_index = 2'd1;
          `ATSP_OFF_CONST_8_11: word_index = 2'd2;
          default:              word_index = 2'd3;
        endcase
      end else begin
        case (a)
          `ATSP_OFF_SW_0_3:  word_index = 2'd0;
          `ATSP_OFF_SW_4_7:  word_index = 2'd1;
          `ATSP_OFF_SW_8_11: word_index = 2'd2;
          default:           word_index = 2'd3;
        endcase
      end
    end
  endfunction

  // keep enable and selector bits, the two reserved bits of each lane forced to zero
  function [31:0] slot_pack;
    input [31:0] d;
    begin
      slot_pack = d & `ATSP_SLOT_WMASK;
    end
  endfunction

  wire [1:0] sw_idx    = word_index(paddr, 1'b0);
  wire [1:0] const_idx = word_index(paddr, 1'b1);

  // ****************************************************************
  // slot program registers
  // ****************************************************************
  // software slot words, four slots to a word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_word[0] <= `ATSP_SLOT_RESET;
      sw_word[1] <= `ATSP_SLOT_RESET;
      sw_word[2] <= `ATSP_SLOT_RESET;
    end else if (wr_ok && sw_idx != 2'd3) begin
      sw_word[sw_idx] <= slot_pack(pwdata);
    end
  end

  // constant slot words, same lane layout as the software words
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      const_word[0] <= `ATSP_SLOT_RESET;
      const_word[1] <= `ATSP_SLOT_RESET;
      const_word[2] <= `ATSP_SLOT_RESET;
    end else if (wr_ok && const_idx != 2'd3) begin
      const_word[const_idx] <= slot_pack(pwdata);
    end
  end

  // ****************************************************************
  // control and interrupt enable registers
  // ****************************************************************
  // start bit is a write-one pulse, it never reads back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      const_mode <= 1'b0;
      sw_start   <= 1'b0;
    end else begin
      sw_start <= 1'b0;
      if (wr_ok && hit_ctrl) begin
        const_mode <= pwdata[`ATSP_CTRL_CONST_MODE];
        sw_start   <= pwdata[`ATSP_CTRL_SW_START];
      end
    end
  end

  // enable mask, same bit layout as the interrupt status
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= {`ATSP_IRQ_W{1'b0}};
    end else if (wr_ok && hit_irq_en) begin
      irq_enable <= pwdata[`ATSP_IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // interrupt status
  // ****************************************************************
  // a new event beats a clear written in the same cycle
  always @* begin
    next_irq_status = irq_status;
    if (wr_ok && hit_irq_clr)
      next_irq_status = irq_status & ~pwdata[`ATSP_IRQ_W-1:0];
    next_irq_status[`ATSP_IRQ_SW_DONE] = next_irq_status[`ATSP_IRQ_SW_DONE] |
                                         sw_done_evt;
    next_irq_status[`ATSP_IRQ_BAD_SEL] = next_irq_status[`ATSP_IRQ_BAD_SEL] | bad_sel_evt;
    next_irq_status[`ATSP_IRQ_ABORT]   = next_irq_status[`ATSP_IRQ_ABORT] | abort_evt;
  end

  // sticky status flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= {`ATSP_IRQ_W{1'b0}};
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // irq line rises with the status bit, always from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_conversion_done_irq <= 1'b0;
    end else begin
      sw_conversion_done_irq <= |(next_irq_status & irq_enable);
    end
  end

  // ****************************************************************
  // apb read mux
  // ****************************************************************
  // unmapped addresses answer with pslverr and zero data
  always @* begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (sw_idx != 2'd3)
      next_prdata = sw_word[sw_idx];
    else if (const_idx != 2'd3)
      next_prdata = const_word[const_idx];
    else begin
      case (paddr)
        `ATSP_OFF_CTRL: begin
          next_prdata[`ATSP_CTRL_CONST_MODE] = const_mode;
        end
        `ATSP_OFF_STATUS: begin
          next_prdata[`ATSP_STAT_BUSY]    = busy;
          next_prdata[`ATSP_STAT_CONST]   = const_active;
          next_prdata[`ATSP_STAT_SW_PEND] = sw_pending;
          next_prdata[`ATSP_STAT_SLOT_LSB +: 4] = conversion_result_slot;
        end
        `ATSP_OFF_IRQ_STATUS: begin
          next_prdata[`ATSP_IRQ_W-1:0] = irq_status;
        end
        `ATSP_OFF_IRQ_CLEAR: begin
          next_prdata = 32'h0000_0000;
        end
        `ATSP_OFF_IRQ_ENABLE: begin
          next_prdata[`ATSP_IRQ_W-1:0] = irq_enable;
        end
        default: begin
          next_slverr = 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // apb handshake
  // ****************************************************************
  // answer captured in setup, so every access ends after one cycle;
  // status read data is therefore one cycle old at the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & next_slverr;
    end
  end

  // read data stands only in the access cycle of a read, zero otherwise
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= next_prdata;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  atsp_slot_seq #(
    .IS_UNIT_B (IS_UNIT_B)
  ) u_seq (
    .pclk                   (pclk),
    .presetn                (presetn),
    .sw_start               (sw_start),
    .const_mode             (const_mode),
    .hi_prio_trigger        (hi_prio_trigger),
    .conv_done              (conv_done),
    .sw_slots               (sw_slots),
    .const_slots            (const_slots),
    .conv_start             (conv_start),
    .conv_channel           (conv_channel),
    .conversion_result_slot (conversion_result_slot),
    .busy                   (busy),
    .const_active           (const_active),
    .sw_pending             (sw_pending),
    .sw_done_evt            (sw_done_evt),
    .bad_sel_evt            (bad_sel_evt),
    .abort_evt              (abort_evt)
  );

endmodule // atsp_top

// ---- tb/atsp_monitor.sv ----
// port-level assertion checker for the trigger slot program block
`timescale 1ns/1ps

module atsp_monitor #(
  parameter IS_UNIT_B = 0
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        hi_prio_trigger,
  input wire        conv_done,
  input wire        conv_start,
  input wire [4:0]  conv_channel,
  input wire [3:0]  conversion_result_slot,
  input wire        sw_conversion_done_irq
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // highest code the unit converts; above it the code is reserved
  wire [4:0] max_code = IS_UNIT_B ? 5'h10 : 5'h0E;

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready in the access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_err_needs_ready: assert property (pslverr |-> pready)
    else $error("error outside access cycle");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h28 |-> pslverr)
    else $error("unmapped access without error");
  a_reserved_zero: assert property (pready && !pwrite && paddr <= 8'h14
    |-> (prdata & 32'h6060_6060) == 32'h0000_0000)
    else $error("reserved slot bits read nonzero");
  a_slot_in_range: assert property (conv_start |-> conversion_result_slot <= 4'hB)
    else $error("result slot beyond eleven");
  a_code_in_range: assert property (conv_start |-> conv_channel <= max_code)
    else $error("reserved input code converted");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start wider than one cycle");
  a_hold_until_start: assert property ($changed(conv_channel)
    || $changed(conversion_result_slot) |-> conv_start)
    else $error("channel or slot moved without a start");
  a_prio_holds_off: assert property (hi_prio_trigger [*4] |-> !conv_start)
    else $error("start while higher priority trigger busy");

  c_conv_start: cover property (conv_start);
  c_slave_err: cover property (pslverr);
  c_irq_rise: cover property ($rose(sw_conversion_done_irq));
endmodule // atsp_monitor

bind atsp_top atsp_monitor #(.IS_UNIT_B(IS_UNIT_B)) i_atsp_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hi_prio_trigger(hi_prio_trigger), .conv_done(conv_done), .conv_start(conv_start),
  .conv_channel(conv_channel), .conversion_result_slot(conversion_result_slot),
  .sw_conversion_done_irq(sw_conversion_done_irq));

// ---- tb/tb.sv ----
// self-checking bench for the trigger slot program block on unit a
`timescale 1ns/1ps
`include "atsp_regs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
  logic        pclk, presetn, psel, penable, pwrite, hi_prio_trigger, conv_done, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, conv_start, sw_conversion_done_irq;
  logic [4:0]  conv_channel;
  logic [3:0]  conversion_result_slot;
  logic [1:0]  done_dly = 2'b00;
  logic [8:0]  conv_log [0:63];
  int          n_conv = 0, cycles = 0, error_cnt = 0, total_checks = 0, k, j;

  atsp_top #(.IS_UNIT_B(0)) i_atsp_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hi_prio_trigger(hi_prio_trigger), .conv_done(conv_done), .conv_start(conv_start),
    .conv_channel(conv_channel), .conversion_result_slot(conversion_result_slot),
    .sw_conversion_done_irq(sw_conversion_done_irq));

  // ****************************************************************
  // clock, converter stand-in, timeout
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // logs every start and answers three cycles later, as a slow core would
  always @(posedge pclk) begin
    done_dly <= {done_dly[0], conv_start};
    conv_done <= done_dly[1];
    if (conv_start === 1'b1) begin
      conv_log[n_conv[5:0]] <= {conversion_result_slot, conv_channel};
      n_conv <= n_conv + 1;
    end
  end

  // ceiling well above the fewer than a thousand cycles the run needs
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ****************************************************************
  // bus tasks
  // ****************************************************************
  // one idle cycle after each transfer keeps psel from being set twice in a step
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rdat, rerr);
    `CHK(rdat, exp)
  endtask

  task irq_is(input logic exp);
    repeat (2) @(posedge pclk);
    `CHK(sw_conversion_done_irq, exp)
  endtask

  // loads slots 0..3, starts the software program and waits for its interrupt
  task sw_run(input logic [31:0] prog, input int nexp, input logic [31:0] stat);
    j = n_conv;
    wr(`ATSP_OFF_SW_0_3, prog);
    wr(`ATSP_OFF_CTRL, 32'h0000_0001);
    for (k = 0; k < 500 && sw_conversion_done_irq !== 1'b1; k++) @(posedge pclk);
    `CHK(sw_conversion_done_irq, 1'b1)
    `CHK(n_conv - j, nexp)
    rd(`ATSP_OFF_IRQ_STATUS, stat);
    wr(`ATSP_OFF_IRQ_CLEAR, 32'h0000_0007);
  endtask

  task give_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    hi_prio_trigger = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(sw_conversion_done_irq, 1'b0)
    // reset value, writable fields and reserved bits of all six slot words
    for (int r = 0; r < 6; r++) begin
      rd(8'(4 * r), 32'h0000_0000);
      wr(8'(4 * r), 32'hFFFF_FFFF);
      rd(8'(4 * r), 32'h9F9F_9F9F);
      wr(8'(4 * r), 32'h0000_0000);
    end
    apb(1'b1, 8'h40, 32'hFFFF_FFFF, rdat, rerr);
    `CHK(rerr, 1'b1)
    apb(1'b0, 8'h40, 32'h0000_0000, rdat, rerr);
    `CHK(rerr, 1'b1)
    `CHK(rdat, 32'h0000_0000)
    wr(`ATSP_OFF_IRQ_ENABLE, 32'h0000_0001);
    // selector codes 0 to 16 in slot 0; 15 and 16 are reserved on this unit
    for (int c = 0; c < 17; c++) begin
      sw_run(32'h0000_0080 | c, (c < 15) ? 1 : 0, (c < 15) ? 32'h1 : 32'h3);
      if (c < 15) `CHK(conv_log[n_conv - 1], {4'h0, 5'(c)})
    end
    // mixed lanes: disabled slot 1 skipped, reserved code in slot 3 flagged
    sw_run(32'h908E_0783, 2, 32'h0000_0003);
    `CHK(conv_log[n_conv - 2], {4'h0, 5'h03})
    `CHK(conv_log[n_conv - 1], {4'h2, 5'h0E})
    // constant program loops over slots 1 and 11
    wr(`ATSP_OFF_CONST_0_3, 32'h0000_8500);
    wr(`ATSP_OFF_CONST_8_11, 32'h8900_0000);
    j = n_conv;
    wr(`ATSP_OFF_CTRL, 32'h0000_0002);
    for (k = 0; k < 400 && n_conv < j + 3; k++) @(posedge pclk);
    `CHK(conv_log[j], {4'h1, 5'h05})
    `CHK(conv_log[j + 1], {4'hB, 5'h09})
    `CHK(conv_log[j + 2], {4'h1, 5'h05})
    // higher priority trigger stops the loop and flags the abort
    hi_prio_trigger <= 1'b1;
    repeat (20) @(posedge pclk);
    j = n_conv;
    repeat (40) @(posedge pclk);
    `CHK(n_conv - j, 0)
    rd(`ATSP_OFF_IRQ_STATUS, 32'h0000_0004);
    rd(`ATSP_OFF_STATUS, 32'h0000_0010);
    rd(`ATSP_OFF_CTRL, 32'h0000_0002);
    irq_is(1'b0);
    wr(`ATSP_OFF_IRQ_ENABLE, 32'h0000_0004);
    irq_is(1'b1);
    wr(`ATSP_OFF_IRQ_ENABLE, 32'h0000_0000);
    irq_is(1'b0);
    wr(`ATSP_OFF_IRQ_ENABLE, 32'h0000_0004);
    wr(`ATSP_OFF_IRQ_CLEAR, 32'h0000_0004);
    irq_is(1'b0);
    rd(`ATSP_OFF_IRQ_STATUS, 32'h0000_0000);
    hi_prio_trigger <= 1'b0;
    wr(`ATSP_OFF_CTRL, 32'h0000_0000);
    // reset in mid-run, with a fresh program and the loop running
    wr(`ATSP_OFF_SW_4_7, 32'h8181_8181);
    wr(`ATSP_OFF_CTRL, 32'h0000_0002);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(sw_conversion_done_irq, 1'b0)
    rd(`ATSP_OFF_SW_4_7, 32'h0000_0000);
    rd(`ATSP_OFF_CONST_0_3, 32'h0000_0000);
    rd(`ATSP_OFF_CTRL, 32'h0000_0000);
    give_verdict();
  end
endmodule // tb
